// ==== include/panel_pkg.sv ====
// constants and types for the feeder localizer front panel
`default_nettype none
package panel_pkg;
   localparam int          FEEDERS      = 16;
   localparam int          FIDX_W       = 4;
   localparam int          VAL_W        = 10;
   localparam int          CLK_HZ       = 20000000;
   localparam int          TIMEOUT_S    = 120;
   localparam int          COPY_S       = 6;
   localparam int          FLASH_MS     = 250;
   localparam int          REP_SLOW_MS  = 400;
   localparam int          REP_FAST_MS  = 50;
   localparam int          REP_DEC_MS   = 50;
   localparam int          COPY_STEP_MS = 500;
   // two minutes of cycles overflows a signed int, so this one is unsigned
   localparam int unsigned TIMEOUT_CYC  = unsigned'(TIMEOUT_S)
                                          * unsigned'(CLK_HZ);
   localparam int          COPY_CYC     = COPY_S * CLK_HZ;
   localparam int          FLASH_CYC    = FLASH_MS * (CLK_HZ / 1000);
   localparam int          REP_SLOW_CYC = REP_SLOW_MS * (CLK_HZ / 1000);
   localparam int          REP_FAST_CYC = REP_FAST_MS * (CLK_HZ / 1000);
   localparam int          REP_DEC_CYC  = REP_DEC_MS * (CLK_HZ / 1000);
   localparam int          COPY_STEP_CYC = COPY_STEP_MS * (CLK_HZ / 1000);
   localparam logic [VAL_W-1:0] VAL_MIN     = 10'h001;
   localparam logic [VAL_W-1:0] VAL_MAX     = 10'h3e7;
   localparam logic [VAL_W-1:0] VAL_CLEARED = 10'h3e7;
   localparam logic [VAL_W-1:0] VAL_INTERM  = 10'h001;
   localparam logic [VAL_W-1:0] THR_RESET   = 10'h00a;
   localparam logic [VAL_W-1:0] VAL_BLANK   = 10'h000;
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_VIEW,
      MODE_MODIFY,
      MODE_COPY,
      MODE_ALARM,
      MODE_CLEAR,
      MODE_SELFTEST
   } mode_t;
endpackage
`default_nettype wire

// ==== design/key_repeat.sv ====
// accelerating key repeat: one step on press, then faster steps while held
`default_nettype none
module key_repeat
   import panel_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_b_in,
   // key level and step pulse
   input  wire logic key_in,
   output logic      step_out
);
   logic        key_r;
   logic        key_nxt;
   logic [23:0] cnt_r;
   logic [23:0] cnt_nxt;
   logic [23:0] per_r;
   logic [23:0] per_nxt;
   logic        step_r;
   logic        step_nxt;

   always_comb
   begin
      key_nxt  = key_in;
      cnt_nxt  = cnt_r;
      per_nxt  = per_r;
      step_nxt = 1'b0;
      if (!key_in)
      begin
         cnt_nxt = 24'h0;
         per_nxt = 24'(REP_SLOW_CYC);
      end
      else if (!key_r)
      begin
         step_nxt = 1'b1;
         cnt_nxt  = 24'h0;
      end
      else if (cnt_r >= per_r - 24'h1)
      begin
         step_nxt = 1'b1;
         cnt_nxt  = 24'h0;
         // period shrinks after every repeat step down to the fast floor
         if (per_r > 24'(REP_FAST_CYC + REP_DEC_CYC))
            per_nxt = per_r - 24'(REP_DEC_CYC);
         else
            per_nxt = 24'(REP_FAST_CYC);
      end
      else
         cnt_nxt = cnt_r + 24'h1;
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         key_r  <= 1'b0;
         cnt_r  <= 24'h0;
         per_r  <= 24'(REP_SLOW_CYC);
         step_r <= 1'b0;
      end
      else
      begin
         key_r  <= key_nxt;
         cnt_r  <= cnt_nxt;
         per_r  <= per_nxt;
         step_r <= step_nxt;
      end
   end

   assign step_out = step_r;

   a_press_steps: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      $rose(key_in) |=> step_r)
      else $error("press did not give a step");
   a_idle_quiet: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      !key_in ##1 !key_in |-> !step_r)
      else $error("step without key");
endmodule
`default_nettype wire

// ==== design/feeder_panel.sv ====
// front panel control of the multi feeder fault localizer
// Function
// - keypad modification path changes only per-feeder fault thresholds.
// - held plus or minus steps slowly, then faster; short press steps once.
// - viewing a feeder flashes its led and shows its threshold in kilohms.
// - two minutes without keys in view or modify returns to normal.
// - after confirming a threshold, copy led flashes for six seconds.
// - plus and confirm in copy window walk feeders, loading same threshold.
// - a fault alarm arising in normal mode shows that feeder's measured resistance automatically.
// - resetting an active alarm de-energizes fault and failsafe relays.
// - intermittent fault display flashes both leds and shows 1 kilohm.
// - intermittent faults clear one feeder per clear action.
// - after clearing show 999, advance to next used feeder still holding an intermittent fault.
// - when all intermittent faults are gone, indicator led goes off.
// - serious self-test failure loops self-test, red led, failsafe relay.
// - toroid short or open logs non-blocking failure and lights red led.
// - blocking errors halt and are not stored; non-blocking are stored.
`default_nettype none
module feeder_panel
   import panel_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int          COPY_CYCLES    = COPY_CYC
)
(
   // clock and reset
   input  wire logic                          sys_clk_in,
   input  wire logic                          rst_b_in,
   // keypad levels
   input  wire logic                          key_plus_in,
   input  wire logic                          key_minus_in,
   input  wire logic                          key_ok_in,
   input  wire logic                          key_select_in,
   input  wire logic                          key_reset_in,
   // measurement side
   input  wire logic [panel_pkg::FEEDERS-1:0] feeder_used_in,
   input  wire logic [panel_pkg::FEEDERS-1:0] fault_alarm_in,
   input  wire logic [panel_pkg::FEEDERS-1:0] interm_event_in,
   input  wire logic [panel_pkg::FEEDERS-1:0] toroid_bad_in,
   input  wire logic [panel_pkg::VAL_W-1:0]   fault_res_in,
   input  wire logic                          selftest_serious_in,
   // display and leds
   output logic [panel_pkg::VAL_W-1:0]        display_val_out,
   output logic [panel_pkg::FIDX_W-1:0]       res_feeder_out,
   output logic [panel_pkg::FEEDERS-1:0]      feeder_led_out,
   output logic                               copy_led_out,
   output logic                               interm_led_out,
   output logic                               red_led_out,
   output logic                               selftest_loop_out,
   // relays
   output logic                               fault_relay_out,
   output logic                               failsafe_relay_out,
   // stored failure log and threshold read back
   output logic [panel_pkg::FEEDERS-1:0]      failure_log_out,
   output logic [panel_pkg::VAL_W-1:0]        thr_sel_out
);
   import panel_pkg::*;

   function automatic logic [FIDX_W-1:0] next_used(
      input logic [FIDX_W-1:0]  cur,
      input logic [FEEDERS-1:0] used);
      logic [FIDX_W-1:0] n;
      logic              hit;
      n   = cur;
      hit = 1'b0;
      for (int i = 1; i <= FEEDERS; i++)
      begin
         if (!hit && used[FIDX_W'(int'(cur) + i)])
         begin
            n   = FIDX_W'(int'(cur) + i);
            hit = 1'b1;
         end
      end
      return n;
   endfunction

   function automatic logic [FIDX_W-1:0] first_set(
      input logic [FEEDERS-1:0] v);
      logic [FIDX_W-1:0] n;
      n = '0;
      for (int i = FEEDERS - 1; i >= 0; i--)
         if (v[i])
            n = FIDX_W'(i);
      return n;
   endfunction

   // one saturating threshold step within the editable range
   function automatic logic [VAL_W-1:0] step_val(
      input logic [VAL_W-1:0] v,
      input logic             up,
      input logic             dn);
      logic [VAL_W-1:0] n;
      n = v;
      if (up && v < VAL_MAX)
         n = v + 10'h001;
      else if (dn && v > VAL_MIN)
         n = v - 10'h001;
      return n;
   endfunction

   logic                  up_step;
   logic                  dn_step;
   logic                  copy_step;
   mode_t                 mode_r, mode_nxt;
   logic [FIDX_W-1:0]     sel_r, sel_nxt;
   logic [VAL_W-1:0]      thr_r [FEEDERS];
   logic [VAL_W-1:0]      thr_nxt [FEEDERS];
   logic [VAL_W-1:0]      edit_r, edit_nxt;
   logic [FEEDERS-1:0]    interm_r, interm_nxt;
   logic [FEEDERS-1:0]    log_r, log_nxt;
   logic                  relays_on_r, relays_on_nxt;
   logic [31:0]           idle_r, idle_nxt;
   logic [31:0]           copy_r, copy_nxt;
   logic [23:0]           flash_r, flash_nxt;
   logic                  blink_r, blink_nxt;
   logic [4:0]            keys_r;
   logic [4:0]            keys_now;
   logic                  any_press;
   logic [VAL_W-1:0]      disp_nxt;
   logic [FEEDERS-1:0]    led_nxt;
   logic                  cleared_r, cleared_nxt;

   key_repeat u_rep_up (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .key_in     (key_plus_in & ~key_ok_in),
      .step_out   (up_step)
   );
   key_repeat u_rep_dn (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .key_in     (key_minus_in),
      .step_out   (dn_step)
   );
   key_repeat u_rep_copy (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .key_in     (key_plus_in & key_ok_in & (mode_r == MODE_COPY)),
      .step_out   (copy_step)
   );

   assign keys_now  = {key_plus_in, key_minus_in, key_ok_in,
                       key_select_in, key_reset_in};
   assign any_press = |(keys_now & ~keys_r);

   always_comb
   begin
      mode_nxt      = mode_r;
      sel_nxt       = sel_r;
      thr_nxt       = thr_r;
      edit_nxt      = edit_r;
      log_nxt       = log_r | toroid_bad_in;
      interm_nxt    = interm_r | interm_event_in;
      relays_on_nxt = relays_on_r | (|fault_alarm_in);
      copy_nxt      = (copy_r != 32'h0) ? copy_r - 32'h1 : 32'h0;
      flash_nxt     = flash_r + 24'h1;
      blink_nxt     = blink_r;
      cleared_nxt   = 1'b0;
      if (flash_r >= 24'(FLASH_CYC - 1))
      begin
         flash_nxt = 24'h0;
         blink_nxt = ~blink_r;
      end
      idle_nxt = any_press ? 32'h0 : idle_r + 32'h1;
      if (selftest_serious_in)
         mode_nxt = MODE_SELFTEST;
      else
         case (mode_r)
            MODE_NORMAL:
            begin
               if (|fault_alarm_in)
               begin
                  mode_nxt = MODE_ALARM;
                  sel_nxt  = first_set(fault_alarm_in);
               end
               else if (key_select_in && !keys_r[1])
               begin
                  mode_nxt = MODE_VIEW;
                  sel_nxt  = next_used(sel_r, feeder_used_in);
               end
               else if (key_ok_in && !keys_r[2] && |interm_r)
               begin
                  mode_nxt = MODE_CLEAR;
                  sel_nxt  = first_set(interm_r);
               end
            end
            MODE_VIEW:
            begin
               if (key_select_in && !keys_r[1])
                  sel_nxt = next_used(sel_r, feeder_used_in);
               else if (up_step || dn_step)
               begin
                  mode_nxt = MODE_MODIFY;
                  edit_nxt = step_val(thr_r[sel_r], up_step, dn_step);
               end
            end
            MODE_MODIFY:
            begin
               // only the fault threshold is editable here
               edit_nxt = step_val(edit_r, up_step, dn_step);
               if (key_ok_in && !keys_r[2])
               begin
                  thr_nxt[sel_r] = edit_r;
                  mode_nxt       = MODE_COPY;
                  copy_nxt       = 32'(COPY_CYCLES);
               end
            end
            MODE_COPY:
            begin
               if (copy_step)
               begin
                  sel_nxt          = next_used(sel_r, feeder_used_in);
                  thr_nxt[next_used(sel_r, feeder_used_in)] = edit_r;
                  copy_nxt         = 32'(COPY_CYCLES);
               end
               else if (copy_r == 32'h0)
                  mode_nxt = MODE_VIEW;
            end
            MODE_ALARM:
            begin
               if (key_reset_in && !keys_r[0])
               begin
                  relays_on_nxt = 1'b0;
                  mode_nxt      = MODE_NORMAL;
               end
               else if (|fault_alarm_in)
                  sel_nxt = first_set(fault_alarm_in);
            end
            MODE_CLEAR:
            begin
               if (key_reset_in && !keys_r[0])
               begin
                  interm_nxt[sel_r] = interm_event_in[sel_r];
                  cleared_nxt       = 1'b1;
                  sel_nxt = next_used(sel_r, feeder_used_in & interm_r
                            & ~(FEEDERS'(1) << sel_r));
                  if ((interm_r & ~(FEEDERS'(1) << sel_r)) == '0)
                     mode_nxt = MODE_NORMAL;
               end
            end
            MODE_SELFTEST:
               mode_nxt = MODE_NORMAL;
            default:
               mode_nxt = MODE_NORMAL;
         endcase
      // a serious self-test failure wins over the inactivity exit
      if ((mode_r == MODE_VIEW || mode_r == MODE_MODIFY
           || mode_r == MODE_CLEAR) && idle_r >= 32'(TIMEOUT_CYCLES - 1)
          && !selftest_serious_in)
         mode_nxt = MODE_NORMAL;
      // display and leds
      disp_nxt = VAL_BLANK;
      led_nxt  = '0;
      case (mode_nxt)
         MODE_VIEW, MODE_COPY:
         begin
            disp_nxt = thr_nxt[sel_nxt];
            led_nxt[sel_nxt] = blink_nxt;
         end
         MODE_MODIFY:
         begin
            disp_nxt = edit_nxt;
            led_nxt[sel_nxt] = blink_nxt;
         end
         MODE_ALARM:
         begin
            disp_nxt = fault_res_in;
            led_nxt  = fault_alarm_in;
         end
         MODE_CLEAR:
         begin
            disp_nxt = cleared_nxt ? VAL_CLEARED : VAL_INTERM;
            led_nxt[sel_nxt] = blink_nxt;
         end
         default:
            led_nxt = '0;
      endcase
      // the last clear leaves clear mode but still shows 999 once
      if (cleared_nxt)
         disp_nxt = VAL_CLEARED;
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         mode_r             <= MODE_NORMAL;
         sel_r              <= '0;
         for (int i = 0; i < FEEDERS; i++)
            thr_r[i] <= THR_RESET;
         edit_r             <= THR_RESET;
         interm_r           <= '0;
         log_r              <= '0;
         relays_on_r        <= 1'b0;
         idle_r             <= 32'h0;
         copy_r             <= 32'h0;
         flash_r            <= 24'h0;
         // flashing starts in the lit phase
         blink_r            <= 1'b1;
         keys_r             <= 5'h00;
         cleared_r          <= 1'b0;
         display_val_out    <= VAL_BLANK;
         res_feeder_out     <= '0;
         feeder_led_out     <= '0;
         copy_led_out       <= 1'b0;
         interm_led_out     <= 1'b0;
         red_led_out        <= 1'b0;
         selftest_loop_out  <= 1'b0;
         fault_relay_out    <= 1'b0;
         failsafe_relay_out <= 1'b0;
         failure_log_out    <= '0;
         thr_sel_out        <= THR_RESET;
      end
      else
      begin
         mode_r             <= mode_nxt;
         sel_r              <= sel_nxt;
         thr_r              <= thr_nxt;
         edit_r             <= edit_nxt;
         interm_r           <= interm_nxt;
         log_r              <= log_nxt;
         relays_on_r        <= relays_on_nxt;
         idle_r             <= idle_nxt;
         copy_r             <= copy_nxt;
         flash_r            <= flash_nxt;
         blink_r            <= blink_nxt;
         keys_r             <= keys_now;
         cleared_r          <= cleared_nxt;
         display_val_out    <= disp_nxt;
         res_feeder_out     <= sel_nxt;
         feeder_led_out     <= led_nxt;
         copy_led_out       <= (copy_nxt != 32'h0) && blink_nxt;
         // the indicator flashes with the feeder led while clearing
         interm_led_out     <= (|interm_nxt) && (blink_nxt
                               || mode_nxt != MODE_CLEAR);
         red_led_out        <= selftest_serious_in | (|log_nxt);
         selftest_loop_out  <= selftest_serious_in;
         fault_relay_out    <= relays_on_nxt;
         failsafe_relay_out <= relays_on_nxt | selftest_serious_in;
         failure_log_out    <= log_nxt;
         thr_sel_out        <= thr_nxt[sel_nxt];
      end
   end

   sequence s_reset_press;
      mode_r == MODE_ALARM && key_reset_in && !keys_r[0]
         && !selftest_serious_in && !(|fault_alarm_in);
   endsequence

   a_alarm_reset: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in)
      s_reset_press |=> !fault_relay_out && !failsafe_relay_out)
      else $error("relays stay on after alarm reset");
   a_serious_st: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in)
      selftest_serious_in |=> red_led_out && failsafe_relay_out
         && mode_r == MODE_SELFTEST)
      else $error("serious self-test not signalled");
   a_toroid_log: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in)
      |toroid_bad_in |=> red_led_out && |failure_log_out)
      else $error("toroid failure not logged");
   a_interm_led: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in)
      interm_r == '0 |-> !interm_led_out)
      else $error("interm led on with nothing stored");
   a_alarm_disp: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in)
      mode_r == MODE_ALARM && mode_nxt == MODE_ALARM
         |=> display_val_out == $past(fault_res_in))
      else $error("alarm value not shown");
   a_copy_window: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in)
      mode_r == MODE_MODIFY && mode_nxt == MODE_COPY
         |=> copy_r == 32'(COPY_CYCLES))
      else $error("copy window not started");
   a_idle_restart: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in)
      any_press |=> idle_r == 32'h0)
      else $error("key press did not restart timer");
   a_one_clear: assert property (@(posedge sys_clk_in)
      disable iff (!rst_b_in)
      cleared_r |-> $countones($past(interm_r) & ~interm_r) <= 1)
      else $error("more than one feeder cleared");
endmodule
`default_nettype wire

// ==== verif/key_operator.sv ====
// behavioural keypad operator that presses and releases panel keys
`default_nettype none
module key_operator
(
   // clock
   input  wire logic sys_clk_in,
   // key levels, high while pressed
   output logic      key_plus_out,
   output logic      key_minus_out,
   output logic      key_ok_out,
   output logic      key_select_out,
   output logic      key_reset_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] keys_r;
   assign {key_reset_out, key_select_out, key_ok_out, key_minus_out,
           key_plus_out} = keys_r;
   initial keys_r = 5'h00;
   // keys change just after an edge; one low cycle lets the next rise count
   task automatic hold(input logic [4:0] k, input int cycles);
      keys_r = k;
      repeat (cycles) @(posedge sys_clk_in);
      #1;
      keys_r = 5'h00;
      @(posedge sys_clk_in);
      #1;
   endtask
endmodule
`default_nettype wire

// ==== verif/test_feeder_panel.sv ====
// self-checking bench for the front panel control block
`default_nettype none
module test_feeder_panel;
   timeunit 1ns;
   timeprecision 1ps;
   import panel_pkg::*;
   localparam int         TMO   = 200;
   localparam int         CPY   = 100;
   localparam logic [4:0] K_PLS = 5'h01;
   localparam logic [4:0] K_MIN = 5'h02;
   localparam logic [4:0] K_OK  = 5'h04;
   localparam logic [4:0] K_SEL = 5'h08;
   localparam logic [4:0] K_RST = 5'h10;
   logic               sys_clk;
   logic               rst_b;
   logic               k_plus, k_minus, k_ok, k_sel, k_rst;
   logic [FEEDERS-1:0] used, alarm, interm, toroid;
   logic [VAL_W-1:0]   fault_res;
   logic               serious;
   logic [VAL_W-1:0]   disp, thr_sel;
   logic [FIDX_W-1:0]  res_feeder;
   logic [FEEDERS-1:0] fled, flog;
   logic               copy_led, interm_led, red_led, st_loop;
   logic               fault_rel, fsafe_rel;
   int                 n_errors;
   int                 n_compared;
   logic               seen;

   key_operator u_op
   (
      .sys_clk_in     (sys_clk),
      .key_plus_out   (k_plus),
      .key_minus_out  (k_minus),
      .key_ok_out     (k_ok),
      .key_select_out (k_sel),
      .key_reset_out  (k_rst)
   );

   feeder_panel #(.TIMEOUT_CYCLES(TMO), .COPY_CYCLES(CPY)) u_dut
   (
      .sys_clk_in          (sys_clk),
      .rst_b_in            (rst_b),
      .key_plus_in         (k_plus),
      .key_minus_in        (k_minus),
      .key_ok_in           (k_ok),
      .key_select_in       (k_sel),
      .key_reset_in        (k_rst),
      .feeder_used_in      (used),
      .fault_alarm_in      (alarm),
      .interm_event_in     (interm),
      .toroid_bad_in       (toroid),
      .fault_res_in        (fault_res),
      .selftest_serious_in (serious),
      .display_val_out     (disp),
      .res_feeder_out      (res_feeder),
      .feeder_led_out      (fled),
      .copy_led_out        (copy_led),
      .interm_led_out      (interm_led),
      .red_led_out         (red_led),
      .selftest_loop_out   (st_loop),
      .fault_relay_out     (fault_rel),
      .failsafe_relay_out  (fsafe_rel),
      .failure_log_out     (flog),
      .thr_sel_out         (thr_sel)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
                          input string what);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_val({15'h0000, got}, {15'h0000, exp}, what);
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic do_reset;
      rst_b     = 1'b0;
      used      = 16'hffff;
      alarm     = 16'h0000;
      interm    = 16'h0000;
      toroid    = 16'h0000;
      fault_res = 10'h000;
      serious   = 1'b0;
      tick(8);
      rst_b = 1'b1;
      tick(1);
   endtask

   // watch the display over the cycles around a single key press
   task automatic press_see(input logic [4:0] k, input logic [9:0] v);
      seen = 1'b0;
      fork
         u_op.hold(k, 1);
         repeat (3)
         begin
            @(negedge sys_clk);
            if (disp === v)
               seen = 1'b1;
         end
      join
   endtask

   task automatic test_idle;
      chk_val(16'(disp), 16'(VAL_BLANK), "idle display");
      chk_val(16'(thr_sel), 16'(THR_RESET), "reset threshold");
      chk_bit(fault_rel | fsafe_rel | red_led | interm_led | copy_led, 1'b0,
              "idle leds and relays");
      chk_val(flog, 16'h0000, "idle failure log");
      $display("test idle done");
   endtask

   task automatic test_view;
      u_op.hold(K_SEL, 1);
      chk_val(16'(disp), 16'(THR_RESET), "view threshold");
      chk_val(fled, 16'h0002, "view led flashes");
      tick(150);
      u_op.hold(K_PLS, 1);
      chk_val(16'(disp), 16'(THR_RESET + 10'h001), "single step");
      tick(150);
      chk_val(16'(disp), 16'(THR_RESET + 10'h001), "timer restart");
      tick(100);
      chk_val(16'(disp), 16'(VAL_BLANK), "inactivity exit");
      $display("test view done");
   endtask

   task automatic test_copy;
      u_op.hold(K_SEL, 1);
      u_op.hold(K_PLS, 1);
      u_op.hold(K_PLS, 1);
      u_op.hold(K_MIN, 1);
      chk_val(16'(disp), 16'(THR_RESET + 10'h001), "up up down");
      u_op.hold(K_PLS, 1);
      u_op.hold(K_OK, 1);
      chk_val(16'(thr_sel), 16'(THR_RESET + 10'h002), "confirm");
      chk_bit(copy_led, 1'b1, "copy led lit");
      u_op.hold(K_PLS | K_OK, 3);
      chk_val(16'(res_feeder), 16'h0002, "copy walk moves");
      chk_val(fled, 16'h0004, "copy walk led");
      chk_val(16'(thr_sel), 16'(THR_RESET + 10'h002), "copy load");
      tick(CPY + 10);
      chk_bit(copy_led, 1'b0, "copy window over");
      $display("test copy done");
   endtask

   task automatic test_alarm;
      fault_res = 10'h02a;
      alarm     = 16'h0004;
      tick(2);
      chk_val(16'(disp), 16'h002a, "alarm value");
      chk_val(16'(res_feeder), 16'h0002, "alarm feeder");
      chk_val(fled, 16'h0004, "alarm led");
      chk_bit(fault_rel & fsafe_rel, 1'b1, "relays energized");
      alarm = 16'h0000;
      u_op.hold(K_RST, 1);
      chk_bit(fault_rel | fsafe_rel, 1'b0, "relays dropped");
      $display("test alarm done");
   endtask

   task automatic test_interm;
      used   = 16'hfff7;
      interm = 16'h0014;
      tick(1);
      interm = 16'h0000;
      tick(1);
      chk_bit(interm_led, 1'b1, "intermittent stored");
      u_op.hold(K_OK, 1);
      chk_val(16'(disp), 16'(VAL_INTERM), "intermittent shown");
      chk_val(16'(res_feeder), 16'h0002, "first pending");
      chk_val(fled, 16'h0004, "pending led flashes");
      press_see(K_RST, VAL_CLEARED);
      chk_bit(seen, 1'b1, "cleared shows 999");
      chk_bit(interm_led, 1'b1, "one cleared only");
      tick(1);
      chk_val(16'(res_feeder), 16'h0004, "skip to next");
      chk_val(16'(disp), 16'(VAL_INTERM), "next shown");
      press_see(K_RST, VAL_CLEARED);
      chk_bit(seen, 1'b1, "second shows 999");
      chk_bit(interm_led, 1'b0, "all cleared");
      $display("test intermittent done");
   endtask

   task automatic test_errors;
      toroid = 16'h0020;
      tick(1);
      toroid = 16'h0000;
      tick(2);
      chk_val(flog, 16'h0020, "toroid logged");
      chk_bit(red_led, 1'b1, "toroid red");
      chk_bit(st_loop, 1'b0, "keeps running");
      serious = 1'b1;
      tick(2);
      chk_bit(st_loop, 1'b1, "self-test loops");
      chk_bit(red_led & fsafe_rel, 1'b1, "red and failsafe");
      chk_val(flog, 16'h0020, "blocking not stored");
      $display("test errors done");
   endtask

   initial
   begin
      n_errors   = 0;
      n_compared = 0;
      do_reset();
      test_idle();
      test_view();
      do_reset();
      test_copy();
      do_reset();
      test_alarm();
      do_reset();
      test_interm();
      do_reset();
      test_errors();
      stop_test();
   end

   // runs take about 600 cycles; cut off a hang well beyond that
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      $display("BAD %0t watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
